// ===== core/sgs_gain_switch.sv
// Gain switch selector: picks normal or alternate loop values and blends between them.
// Assumes a classic Wishbone master and normal loop values from same-clock logic.
//
// Function
// - Condition met: use alternate four loop values
// - Source: off, remote bit, frequency, droop, speed
// - Polarity 0 above/on, 1 below/off
// - Threshold 0 to 9999, default 10
// - Transition time constant 0 to 100 ms
// - Alternate gains only with auto tuning disabled
// - Inertia 0..300.0 default 7.0; position 1..2000
// - Speed 20..20000; integral 0.1..5000.0 ms
// - Alternate vibration, resonance frequencies 0.1..100.0 Hz
// - Alternate frequencies: manual tuning, remote source
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sgs_gain_switch
    import sgs_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [5:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    input  wire logic        remote_switch_in,
    input  wire logic [15:0] cmd_freq_in,
    input  wire logic [15:0] droop_pulses_in,
    input  wire logic [15:0] motor_speed_in,
    input  wire logic [15:0] norm_inertia_in,
    input  wire logic [15:0] norm_pos_gain_in,
    input  wire logic [15:0] norm_speed_gain_in,
    input  wire logic [15:0] norm_integral_in,
    input  wire logic [15:0] norm_vib_freq_in,
    input  wire logic [15:0] norm_res_freq_in,
    output logic      [15:0] act_inertia_out,
    output logic      [15:0] act_pos_gain_out,
    output logic      [15:0] act_speed_gain_out,
    output logic      [15:0] act_integral_out,
    output logic      [15:0] act_vib_freq_out,
    output logic      [15:0] act_res_freq_out,
    output logic             gains_switched_out
);
    // Registers
    logic [15:0] gain_switch_select_reg;
    logic [15:0] gain_switch_threshold_reg;
    logic [15:0] gain_switch_time_constant_reg;
    logic [15:0] alt_inertia_ratio_reg;
    logic [15:0] alt_position_loop_gain_reg;
    logic [15:0] alt_speed_loop_gain_reg;
    logic [15:0] alt_speed_integral_comp_reg;
    logic [15:0] alt_vibration_frequency_reg;
    logic [15:0] alt_resonance_frequency_reg;
    logic [15:0] mode_setting_reg;

    // Control state
    logic [10:0] div_reg;
    logic        tick_reg;
    logic        sync1_reg;
    logic        sync2_reg;
    logic        cond_reg;
    logic        gains_ok;
    logic        freqs_ok;
    logic        wb_req;
    logic [3:0]  idx;
    logic [15:0] wr_merged;
    logic [15:0] rd_word;
    logic [15:0] status_word;
    logic        cond_next;
    logic [15:0] cmp_value;
    logic [3:0]  src_field;
    logic [3:0]  pol_field;
    logic [6:0]  w;

    sgs_ramp_if rif ();

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo)
            r = lo;
        else if (v > hi)
            r = hi;
        return r;
    endfunction

    // Weighted mix; weight runs 0..100
    function automatic logic [15:0] mix(input logic [15:0] n, input logic [15:0] a, input logic [6:0] wt);
        logic signed [24:0] d;
        logic signed [24:0] p;
        logic signed [24:0] r;
        d = $signed({9'h000, a}) - $signed({9'h000, n});
        p = d * $signed({18'h00000, wt});
        r = $signed({9'h000, n}) + p / $signed({18'h00000, SGS_W_FULL});
        return r[15:0];
    endfunction

    assign src_field = gain_switch_select_reg[SGS_SEL_SRC_LSB +: 4];
    assign pol_field = gain_switch_select_reg[SGS_SEL_POL_LSB +: 4];
    assign idx       = wb_adr_in[5:2];
    assign wb_req    = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign w         = rif.weight;

    // Alternate gains only with auto tuning off
    assign gains_ok = (mode_setting_reg[SGS_MODE_AT_LSB +: 4] == SGS_AT_DISABLED);
    // Alternate frequencies need manual tuning and the remote source
    assign freqs_ok = (mode_setting_reg[SGS_MODE_VT_LSB +: 4] == SGS_VT_MANUAL)
                   && (src_field == SGS_SRC_REMOTE);

    // Byte lanes of the low half merge over the current value
    always_comb
    begin
        unique case (idx)
            SGS_IDX_SEL:   rd_word = gain_switch_select_reg;
            SGS_IDX_THR:   rd_word = gain_switch_threshold_reg;
            SGS_IDX_TC:    rd_word = gain_switch_time_constant_reg;
            SGS_IDX_INER:  rd_word = alt_inertia_ratio_reg;
            SGS_IDX_PGAIN: rd_word = alt_position_loop_gain_reg;
            SGS_IDX_VGAIN: rd_word = alt_speed_loop_gain_reg;
            SGS_IDX_INTEG: rd_word = alt_speed_integral_comp_reg;
            SGS_IDX_VFREQ: rd_word = alt_vibration_frequency_reg;
            SGS_IDX_RFREQ: rd_word = alt_resonance_frequency_reg;
            SGS_IDX_MODE:  rd_word = mode_setting_reg;
            SGS_IDX_STAT:  rd_word = status_word;
            SGS_IDX_RSVD:  rd_word = SGS_RST_RSVD;
            default:       rd_word = 16'h0000;
        endcase
        wr_merged[7:0]  = wb_sel_in[0] ? wb_dat_in[7:0]  : rd_word[7:0];
        wr_merged[15:8] = wb_sel_in[1] ? wb_dat_in[15:8] : rd_word[15:8];
    end

    assign status_word = {1'b0, w, 5'h00, freqs_ok && cond_reg, gains_ok && cond_reg, cond_reg};

    // Bus answer: ack one cycle after the request, then drops
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end
        else
        begin
            wb_ack_out <= wb_req;
            if (wb_req && !wb_we_in)
                wb_dat_out <= {16'h0000, rd_word};
        end
    end

    // Writes to ranged registers saturate into the accepted range; select and mode are stored as written
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            gain_switch_select_reg        <= SGS_RST_SEL;
            gain_switch_threshold_reg     <= SGS_RST_THR;
            gain_switch_time_constant_reg <= SGS_RST_TC;
            alt_inertia_ratio_reg         <= SGS_RST_INER;
            alt_position_loop_gain_reg    <= SGS_RST_PGAIN;
            alt_speed_loop_gain_reg       <= SGS_RST_VGAIN;
            alt_speed_integral_comp_reg   <= SGS_RST_INTEG;
            alt_vibration_frequency_reg   <= SGS_RST_FREQ;
            alt_resonance_frequency_reg   <= SGS_RST_FREQ;
            mode_setting_reg              <= SGS_RST_MODE;
        end
        else if (wb_req && wb_we_in)
        begin
            unique case (idx)
                SGS_IDX_SEL:   gain_switch_select_reg        <= wr_merged;
                SGS_IDX_THR:   gain_switch_threshold_reg     <= clamp(wr_merged, 16'h0000, SGS_MAX_THR);
                SGS_IDX_TC:    gain_switch_time_constant_reg <= clamp(wr_merged, 16'h0000, SGS_MAX_TC);
                SGS_IDX_INER:  alt_inertia_ratio_reg         <= clamp(wr_merged, 16'h0000, SGS_MAX_INER);
                SGS_IDX_PGAIN: alt_position_loop_gain_reg    <= clamp(wr_merged, SGS_MIN_PGAIN, SGS_MAX_PGAIN);
                SGS_IDX_VGAIN: alt_speed_loop_gain_reg       <= clamp(wr_merged, SGS_MIN_VGAIN, SGS_MAX_VGAIN);
                SGS_IDX_INTEG: alt_speed_integral_comp_reg   <= clamp(wr_merged, SGS_MIN_INTEG, SGS_MAX_INTEG);
                SGS_IDX_VFREQ: alt_vibration_frequency_reg   <= clamp(wr_merged, SGS_MIN_FREQ, SGS_MAX_FREQ);
                SGS_IDX_RFREQ: alt_resonance_frequency_reg   <= clamp(wr_merged, SGS_MIN_FREQ, SGS_MAX_FREQ);
                SGS_IDX_MODE:  mode_setting_reg              <= wr_merged;
                default:       ;
            endcase
        end
    end

    // Control cycle divider
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            div_reg  <= 11'h000;
            tick_reg <= 1'b0;
        end
        else if (div_reg == 11'(SGS_TICK_CYC - 1))
        begin
            div_reg  <= 11'h000;
            tick_reg <= 1'b1;
        end
        else
        begin
            div_reg  <= div_reg + 11'h001;
            tick_reg <= 1'b0;
        end
    end

    // Remote bit comes from a pin: two flops first
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= remote_switch_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Condition decode
    always_comb
    begin
        unique case (src_field)
            SGS_SRC_CMDF:  cmp_value = cmd_freq_in;
            SGS_SRC_DROOP: cmp_value = droop_pulses_in;
            SGS_SRC_SPEED: cmp_value = motor_speed_in;
            default:       cmp_value = 16'h0000;
        endcase
        cond_next = 1'b0;
        if (src_field == SGS_SRC_REMOTE)
            cond_next = (pol_field == SGS_POL_BELOW) ? !sync2_reg : sync2_reg;
        else if (src_field == SGS_SRC_CMDF || src_field == SGS_SRC_DROOP || src_field == SGS_SRC_SPEED)
            cond_next = (pol_field == SGS_POL_BELOW) ? (cmp_value < gain_switch_threshold_reg)
                                                     : (cmp_value > gain_switch_threshold_reg);
    end

    // Sampled once per control cycle; unknown source codes count as off
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            cond_reg <= 1'b0;
        else if (tick_reg)
            cond_reg <= cond_next;
    end

    assign rif.tick   = tick_reg;
    assign rif.target = cond_reg;
    assign rif.tc     = gain_switch_time_constant_reg[6:0];

    sgs_ramp u_ramp (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .rp        (rif)
    );

    // Active values; gated groups fall back to normal values
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            act_inertia_out    <= 16'h0000;
            act_pos_gain_out   <= 16'h0000;
            act_speed_gain_out <= 16'h0000;
            act_integral_out   <= 16'h0000;
            gains_switched_out <= 1'b0;
        end
        else
        begin
            act_inertia_out    <= mix(norm_inertia_in,    alt_inertia_ratio_reg,       gains_ok ? w : 7'h00);
            act_pos_gain_out   <= mix(norm_pos_gain_in,   alt_position_loop_gain_reg,  gains_ok ? w : 7'h00);
            act_speed_gain_out <= mix(norm_speed_gain_in, alt_speed_loop_gain_reg,     gains_ok ? w : 7'h00);
            act_integral_out   <= mix(norm_integral_in,   alt_speed_integral_comp_reg, gains_ok ? w : 7'h00);
            gains_switched_out <= gains_ok && cond_reg;
        end
    end

    // Frequencies blend with the ramp too; host keeps the motor still meanwhile
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            act_vib_freq_out <= 16'h0000;
            act_res_freq_out <= 16'h0000;
        end
        else
        begin
            act_vib_freq_out <= mix(norm_vib_freq_in, alt_vibration_frequency_reg, freqs_ok ? w : 7'h00);
            act_res_freq_out <= mix(norm_res_freq_in, alt_resonance_frequency_reg, freqs_ok ? w : 7'h00);
        end
    end
endmodule
`default_nettype wire

// ===== core/sgs_pkg.sv
// Package for the gain switch selector: register map, field layout, ranges, resets, timing.
// Assumes a 125 MHz clock and a 32-bit classic Wishbone register bus.
package sgs_pkg;
    // Register indices; byte address is index times four
    localparam logic [3:0] SGS_IDX_RSVD   = 4'h0;
    localparam logic [3:0] SGS_IDX_SEL    = 4'h1;
    localparam logic [3:0] SGS_IDX_THR    = 4'h2;
    localparam logic [3:0] SGS_IDX_TC     = 4'h3;
    localparam logic [3:0] SGS_IDX_INER   = 4'h4;
    localparam logic [3:0] SGS_IDX_PGAIN  = 4'h5;
    localparam logic [3:0] SGS_IDX_VGAIN  = 4'h6;
    localparam logic [3:0] SGS_IDX_INTEG  = 4'h7;
    localparam logic [3:0] SGS_IDX_VFREQ  = 4'h8;
    localparam logic [3:0] SGS_IDX_RFREQ  = 4'h9;
    localparam logic [3:0] SGS_IDX_MODE   = 4'hA;
    localparam logic [3:0] SGS_IDX_STAT   = 4'hB;

    // Field positions
    localparam int SGS_SEL_SRC_LSB  = 0;
    localparam int SGS_SEL_POL_LSB  = 4;
    localparam int SGS_MODE_AT_LSB  = 0;
    localparam int SGS_MODE_VT_LSB  = 4;
    localparam int SGS_STAT_COND    = 0;
    localparam int SGS_STAT_GAINS   = 1;
    localparam int SGS_STAT_FREQS   = 2;
    localparam int SGS_STAT_W_LSB   = 8;

    // Condition sources and digit codes
    typedef enum logic [3:0] {
        SGS_SRC_OFF    = 4'h0,
        SGS_SRC_REMOTE = 4'h1,
        SGS_SRC_CMDF   = 4'h2,
        SGS_SRC_DROOP  = 4'h3,
        SGS_SRC_SPEED  = 4'h4
    } sgs_src_t;
    localparam logic [3:0] SGS_POL_ABOVE   = 4'h0;
    localparam logic [3:0] SGS_POL_BELOW   = 4'h1;
    localparam logic [3:0] SGS_AT_DISABLED = 4'h3;
    localparam logic [3:0] SGS_VT_MANUAL   = 4'h2;

    // Reset values
    localparam logic [15:0] SGS_RST_RSVD  = 16'h0000;
    localparam logic [15:0] SGS_RST_SEL   = 16'h0000;
    localparam logic [15:0] SGS_RST_THR   = 16'h000A;
    localparam logic [15:0] SGS_RST_TC    = 16'h0001;
    localparam logic [15:0] SGS_RST_INER  = 16'h0046;
    localparam logic [15:0] SGS_RST_PGAIN = 16'h0025;
    localparam logic [15:0] SGS_RST_VGAIN = 16'h0337;
    localparam logic [15:0] SGS_RST_INTEG = 16'h0151;
    localparam logic [15:0] SGS_RST_FREQ  = 16'h03E8;
    localparam logic [15:0] SGS_RST_MODE  = 16'h0001;

    // Accepted ranges, in 0.1 units where the value has a decimal
    localparam logic [15:0] SGS_MAX_THR   = 16'h270F;
    localparam logic [15:0] SGS_MAX_TC    = 16'h0064;
    localparam logic [15:0] SGS_MAX_INER  = 16'h0BB8;
    localparam logic [15:0] SGS_MIN_PGAIN = 16'h0001;
    localparam logic [15:0] SGS_MAX_PGAIN = 16'h07D0;
    localparam logic [15:0] SGS_MIN_VGAIN = 16'h0014;
    localparam logic [15:0] SGS_MAX_VGAIN = 16'h4E20;
    localparam logic [15:0] SGS_MIN_INTEG = 16'h0001;
    localparam logic [15:0] SGS_MAX_INTEG = 16'hC350;
    localparam logic [15:0] SGS_MIN_FREQ  = 16'h0001;
    localparam logic [15:0] SGS_MAX_FREQ  = 16'h03E8;

    // Timing: one control cycle of 10 us; a ramp of 100 steps spans tc ms
    localparam int SGS_CLK_PS      = 8000;
    localparam int SGS_TICK_NS     = 10;
    localparam int SGS_TICK_PS     = SGS_TICK_NS * 1000 * 1000 / 1000;
    localparam int SGS_TICK_CYC    = SGS_TICK_NS * 1000 * 1000 / SGS_CLK_PS;
    localparam logic [6:0] SGS_W_FULL = 7'h64;
endpackage

// ===== core/sgs_ramp_if.sv
// Interface between the selector and its transition ramp.
// Assumes both ends run on the one control clock.
`timescale 1ns/1ps
`default_nettype none
interface sgs_ramp_if;
    logic       tick;
    logic       target;
    logic [6:0] tc;
    logic [6:0] weight;
    modport ctrl (output tick, output target, output tc, input weight);
    modport ramp (input tick, input target, input tc, output weight);
endinterface
`default_nettype wire

// ===== core/sgs_ramp.sv
// Transition ramp: moves a 0..100 weight toward its target, one step per tc ticks.
// Assumes one tick each 10 us, so 100 steps take tc ms.
`timescale 1ns/1ps
`default_nettype none
module sgs_ramp
    import sgs_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    sgs_ramp_if.ramp  rp
);
    logic [6:0] cnt_reg;
    logic       tgt_reg;
    logic       step;
    logic [6:0] goal;

    assign goal = rp.target ? SGS_W_FULL : 7'h00;
    assign step = rp.tick && ((rp.tc == 7'h00) || (cnt_reg + 7'h01 >= rp.tc));

    // Step pacing restarts whenever the condition result flips
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt_reg <= 7'h00;
            tgt_reg <= 1'b0;
        end
        else
        begin
            tgt_reg <= rp.target;
            if (rp.target != tgt_reg)
                cnt_reg <= 7'h00;
            else if (step)
                cnt_reg <= 7'h00;
            else if (rp.tick)
                cnt_reg <= cnt_reg + 7'h01;
        end
    end

    // Zero time constant jumps to the goal on the next tick; otherwise linear over tc ms
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            rp.weight <= 7'h00;
        else if (rp.tc == 7'h00 && rp.tick)
            rp.weight <= goal;
        else if (step && rp.weight < goal)
            rp.weight <= rp.weight + 7'h01;
        else if (step && rp.weight > goal)
            rp.weight <= rp.weight - 7'h01;
    end
endmodule
`default_nettype wire

// ===== bench/sgs_gain_switch_monitor.sv
// Port checker for the gain switch selector.
// Assumes it is bound onto sgs_gain_switch.
`timescale 1ns/1ps
`default_nettype none
module sgs_gain_switch_monitor
    import sgs_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [5:0]  wb_adr_in,
    input  wire logic [31:0] wb_dat_out,
    input  wire logic        wb_ack_out,
    input  wire logic        gains_switched_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    wire logic       rd_ack = wb_ack_out && !wb_we_in;
    wire logic [3:0] idx    = wb_adr_in[5:2];
    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_ans;
        wb_ack_out ##1 !wb_ack_out;
    endsequence
    a_ack_one_pulse: assert property (s_req |=> s_ans)
        else $error("ack is not one pulse after a request");
    a_ack_has_req: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without a request");
    a_upper_half_zero: assert property (rd_ack |-> wb_dat_out[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    // Read data must not wander between reads
    a_read_data_held: assert property ($changed(wb_dat_out) |-> rd_ack)
        else $error("read data changed outside a read");
    a_unmapped_zero: assert property (rd_ack && (idx > SGS_IDX_STAT || idx == SGS_IDX_RSVD) |-> wb_dat_out == 32'h0)
        else $error("unmapped or reserved read not zero");
    // Flag and status word both come from the condition of the cycle before the ack
    a_status_cond: assert property (rd_ack && idx == SGS_IDX_STAT && gains_switched_out
        |-> wb_dat_out[SGS_STAT_COND] && wb_dat_out[SGS_STAT_GAINS]) else $error("switched without condition");
    a_thr_range: assert property (rd_ack && idx == SGS_IDX_THR |-> wb_dat_out[15:0] <= SGS_MAX_THR)
        else $error("threshold above range");
    a_tc_range: assert property (rd_ack && idx == SGS_IDX_TC |-> wb_dat_out[15:0] <= SGS_MAX_TC)
        else $error("time constant above range");
endmodule
bind sgs_gain_switch sgs_gain_switch_monitor u_mon (.clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .gains_switched_out(gains_switched_out));
`default_nettype wire

// ===== bench/sgs_host_model.sv
// Host controller model: classic Wishbone master plus the remote switch bit.
// Assumes a slave that acks; every wait is bounded and a miss sets hung.
`timescale 1ns/1ps
`default_nettype none
module sgs_host_model
    import sgs_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic [15:0] motor_speed_in,
    input  wire logic [31:0] wb_dat_in,
    input  wire logic        wb_ack_in,
    output logic             wb_cyc_out,
    output logic             wb_stb_out,
    output logic             wb_we_out,
    output logic [5:0]       wb_adr_out,
    output logic [3:0]       wb_sel_out,
    output logic [31:0]      wb_dat_out,
    output logic             remote_out
);
    logic hung;
    initial
    begin
        {wb_cyc_out, wb_stb_out, wb_we_out, remote_out, hung} = 5'h00;
        {wb_adr_out, wb_sel_out, wb_dat_out} = 42'h0;
    end
    task automatic xfer(input logic w, input logic [3:0] x, input logic [3:0] s, input logic [15:0] d,
                        output logic [15:0] r);
        int n;
        r = 16'h0000;
        n = 0;
        if (w && x == SGS_IDX_RSVD)
            return;
        @(posedge clk_in);
        {wb_cyc_out, wb_stb_out, wb_we_out} <= {2'b11, w};
        {wb_adr_out, wb_sel_out} <= {x, 2'b00, s};
        wb_dat_out <= {16'h0000, d};
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (wb_ack_in !== 1'b1 && n < 64);
        hung |= (wb_ack_in !== 1'b1);
        r = wb_dat_in[15:0];
        {wb_cyc_out, wb_stb_out} <= 2'b00;
        // Released data shows the inverse, so stale data cannot pass
        wb_dat_out <= ~{16'h0000, d};
        @(posedge clk_in);
    endtask
    // Switching while moving jolts the loop, so wait for standstill
    task automatic set_remote(input logic v);
        int n;
        n = 0;
        while (motor_speed_in !== 16'h0000 && n < 64)
        begin
            @(posedge clk_in);
            n++;
        end
        hung |= (motor_speed_in !== 16'h0000);
        @(posedge clk_in);
        remote_out <= v;
    endtask
endmodule
`default_nettype wire

// ===== bench/servo_gain_switch_selector_bench.sv
// Bench for the gain switch selector: register rows, switch rows, ramp and reset cases.
// Assumes the host model as bus master; one tick is SGS_TICK_CYC clocks.
`timescale 1ns/1ps
`default_nettype none
module servo_gain_switch_selector_bench
    import sgs_pkg::*;
;
    typedef struct packed {logic w; logic [3:0] x; logic [15:0] d; logic [15:0] e;} sgs_reg_row_t;
    typedef struct packed {logic [7:0] sel; logic [7:0] mode; logic r; logic [15:0] v; logic g; logic f;} sgs_sw_row_t;
    logic        clk_in, arst_n_in, cyc, stb, we, ack, rem, gsw;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [15:0] val, nv, rd;
    logic [15:0] act [6];
    logic [6:0]  w1;
    int          bad_count, checks_done;
    sgs_reg_row_t regs [23] = '{
        '{1'h0, 4'h0, 16'h0, 16'h0000}, '{1'h0, 4'h1, 16'h0, 16'h0000}, '{1'h0, 4'h2, 16'h0, 16'h000A},
        '{1'h0, 4'h3, 16'h0, 16'h0001}, '{1'h0, 4'h4, 16'h0, 16'h0046}, '{1'h0, 4'h5, 16'h0, 16'h0025},
        '{1'h0, 4'h6, 16'h0, 16'h0337}, '{1'h0, 4'h7, 16'h0, 16'h0151}, '{1'h0, 4'h8, 16'h0, 16'h03E8},
        '{1'h0, 4'h9, 16'h0, 16'h03E8}, '{1'h0, 4'hA, 16'h0, 16'h0001}, '{1'h0, 4'hC, 16'h0, 16'h0000},
        '{1'h1, 4'h2, 16'hFFFF, 16'h270F}, '{1'h1, 4'h3, 16'h00FF, 16'h0064}, '{1'h1, 4'h4, 16'hFFFF, 16'h0BB8},
        '{1'h1, 4'h5, 16'h0000, 16'h0001}, '{1'h1, 4'h6, 16'hFFFF, 16'h4E20}, '{1'h1, 4'h7, 16'h0000, 16'h0001},
        '{1'h1, 4'h8, 16'hFFFF, 16'h03E8}, '{1'h1, 4'h9, 16'h0000, 16'h0001}, '{1'h1, 4'h6, 16'h0005, 16'h0014},
        '{1'h1, 4'h2, 16'h000A, 16'h000A}, '{1'h1, 4'h3, 16'h0000, 16'h0000}};
    // Inputs: command freq val+1, droop val-1, speed val, so a wrong source shows
    sgs_sw_row_t sw [13] = '{
        '{8'h00, 8'h03, 1'h1, 16'h0, 1'h0, 1'h0}, '{8'h01, 8'h03, 1'h1, 16'h0, 1'h1, 1'h0},
        '{8'h11, 8'h03, 1'h1, 16'h0, 1'h0, 1'h0}, '{8'h11, 8'h03, 1'h0, 16'h0, 1'h1, 1'h0},
        '{8'h02, 8'h03, 1'h0, 16'h9, 1'h0, 1'h0}, '{8'h12, 8'h03, 1'h0, 16'h8, 1'h1, 1'h0},
        '{8'h03, 8'h03, 1'h0, 16'hB, 1'h0, 1'h0}, '{8'h13, 8'h03, 1'h0, 16'hA, 1'h1, 1'h0},
        '{8'h04, 8'h03, 1'h0, 16'hB, 1'h1, 1'h0}, '{8'h14, 8'h03, 1'h0, 16'hA, 1'h0, 1'h0},
        '{8'h01, 8'h01, 1'h1, 16'h0, 1'h0, 1'h0}, '{8'h01, 8'h23, 1'h1, 16'h0, 1'h1, 1'h1},
        '{8'h02, 8'h23, 1'h0, 16'hA, 1'h1, 1'h0}};
    sgs_gain_switch DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .remote_switch_in(rem), .cmd_freq_in(val + 16'h0001), .droop_pulses_in(val - 16'h0001),
        .motor_speed_in(val), .norm_inertia_in(nv), .norm_pos_gain_in(nv + 16'h0001),
        .norm_speed_gain_in(nv + 16'h0002), .norm_integral_in(nv + 16'h0003), .norm_vib_freq_in(nv + 16'h0004),
        .norm_res_freq_in(nv + 16'h0005), .act_inertia_out(act[0]), .act_pos_gain_out(act[1]),
        .act_speed_gain_out(act[2]), .act_integral_out(act[3]), .act_vib_freq_out(act[4]),
        .act_res_freq_out(act[5]), .gains_switched_out(gsw));
    sgs_host_model host (.clk_in(clk_in), .motor_speed_in(val), .wb_dat_in(rdat), .wb_ack_in(ack),
        .wb_cyc_out(cyc), .wb_stb_out(stb), .wb_we_out(we), .wb_adr_out(adr), .wb_sel_out(sel),
        .wb_dat_out(wdat), .remote_out(rem));
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic mism(input string m);
        bad_count++;
        $display("mismatch at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        checks_done++;
        if (g !== e)
            mism(m);
    endtask
    task automatic bus(input logic w, input logic [3:0] x, input logic [15:0] d, input logic [3:0] s = 4'h3);
        host.xfer(w, x, s, d, rd);
        if (host.hung === 1'b1)
        begin
            mism("bus or remote wait timed out");
            stop_test();
        end
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever
            #4 clk_in = ~clk_in;
    end
    initial
    begin
        arst_n_in = 1'b0;
        val = 16'h0000;
        nv = 16'h0100;
        bad_count = 0;
        checks_done = 0;
        repeat (20) @(posedge clk_in);
        arst_n_in <= 1'b1;
        foreach (regs[i])
        begin
            if (regs[i].w)
                bus(1'b1, regs[i].x, regs[i].d);
            bus(1'b0, regs[i].x, 16'h0000);
            chk(rd, regs[i].e, "register read-back");
        end
        bus(1'b1, SGS_IDX_THR, 16'h1200, 4'h2);
        bus(1'b0, SGS_IDX_THR, 16'h0000);
        chk(rd, 16'h120A, "byte lane write");
        bus(1'b1, SGS_IDX_THR, 16'h000A);
        for (int k = 4; k < 10; k++)
            bus(1'b1, k[3:0], 16'h0200 + k[15:0]);
        foreach (sw[i])
        begin
            val <= 16'h0000;
            host.set_remote(sw[i].r);
            bus(1'b1, SGS_IDX_SEL, {8'h00, sw[i].sel});
            bus(1'b1, SGS_IDX_MODE, {8'h00, sw[i].mode});
            val <= sw[i].v;
            nv <= nv + 16'h0010;
            repeat (3 * SGS_TICK_CYC + 20) @(posedge clk_in);
            chk({15'h0000, gsw}, {15'h0000, sw[i].g}, "switched flag");
            for (int j = 0; j < 6; j++)
                chk(act[j], ((j < 4) ? sw[i].g : sw[i].f) ? 16'h0204 + j[15:0] : nv + j[15:0], "active value");
        end
        // Slow ramp down, then reverse after about ten steps
        bus(1'b1, SGS_IDX_TC, 16'h0001);
        bus(1'b1, SGS_IDX_SEL, 16'h0012);
        repeat (10 * SGS_TICK_CYC) @(posedge clk_in);
        bus(1'b0, SGS_IDX_STAT, 16'h0000);
        w1 = rd[14:8];
        chk({15'h0000, w1 > 7'd85 && w1 < 7'd99}, 16'h0001, "ramp pace");
        chk({15'h0000, act[1] > nv + 16'h0001 && act[1] < 16'h0205}, 16'h0001, "blend");
        bus(1'b1, SGS_IDX_SEL, 16'h0002);
        repeat (4 * SGS_TICK_CYC) @(posedge clk_in);
        bus(1'b0, SGS_IDX_STAT, 16'h0000);
        chk({15'h0000, rd[14:8] > w1}, 16'h0001, "ramp reversal");
        arst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk(act[1], 16'h0000, "active value in reset");
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk(act[1], nv + 16'h0001, "normal value after reset");
        bus(1'b0, SGS_IDX_TC, 16'h0000);
        chk(rd, SGS_RST_TC, "time constant after reset");
        stop_test();
    end
endmodule
`default_nettype wire
